// file: hdl/eii_pkg.sv
/*
 * constants, field layouts and carrier types for the external
 * interrupt input block: six filtered pins raising request pulses.
 * assumes one 20 MHz core clock that also serves as the gear clock,
 * and a one-cycle low-frequency tick supplied by the system.
 */
// Function
// - channel 4 captures filtered level at bit 4
// - captured level refreshed on every channel 4 request
// - code 01 falling edge, 10 both edges
// - code 00 rising edge, 11 high level on channel 4 only
// - fast interval: gear clock /1,/4,/8,/16
// - fast mode: three agreeing samples accept level on channels 1-4
// - slow mode: fs/4 sampling, two samples agree
// - channels 1-4 fast: 2 to 3 periods window
// - channels 0,5 fast: 1 to 2 clocks window
// - slow mode: 4/fs noise, 8/fs signal
// - channels 0 and 5 fixed falling edge
// - control bits 7 to 5 read zero
// - clock gate 0 stops interrupt logic
// - clock gate clears to 0 on reset
`default_nettype none
package eii_pkg;
   localparam int          EII_NCH        = 6;
   localparam logic [11:0] EII_CTRL4_ADDR = 12'hFDB;
   localparam logic [11:0] EII_POFF3_ADDR = 12'hFD4;
   localparam logic [7:0]  EII_CTRL4_RST  = 8'h00;
   localparam logic        EII_GATE_RST   = 1'h0;
   localparam int          EII_LVL_BIT    = 4;
   localparam int          EII_ES_LSB     = 2;
   localparam int          EII_NC_LSB     = 0;
   localparam int          EII_GATE_BIT   = 0;
   localparam logic [1:0]  EII_LF_LAST    = 2'h3; // fs divided by 4
   localparam logic [1:0]  EII_ES_RISE    = 2'h0;
   localparam logic [1:0]  EII_ES_FALL    = 2'h1;
   localparam logic [1:0]  EII_ES_BOTH    = 2'h2;
   localparam logic [1:0]  EII_ES_HIGH    = 2'h3;

   // register port request
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [11:0] addr;
      logic [7:0]  wdata;
   } eii_bus_type;

   // per-channel settings held outside the block
   typedef struct packed {
      logic [1:0] trigger_select;
      logic [1:0] sample_interval_select;
   } eii_cfg_type;

   typedef struct packed {
      logic [3:0] cnt;
      logic [1:0] lfc;
   } eii_div_type;

   typedef struct packed {
      logic [1:0] hist;
      logic       lvl;
   } eii_nc_type;

   typedef struct packed {
      logic       ext_irq_clock_gate;
      logic [1:0] trigger_select;
      logic [1:0] sample_interval_select;
      logic       captured_pass_level;
      logic [5:0] prev;
      logic [5:0] req;
      logic [7:0] rdata;
   } eii_top_type;
endpackage : eii_pkg
`default_nettype wire

// file: hdl/eii_div.sv
/*
 * sampling tick generator for one channel's noise canceller.
 * assumes lf_tick is a one-cycle pulse at the low-frequency rate.
 */
`default_nettype none
module eii_div (
   input  wire logic       core_clk,
   input  wire logic       rst_n,
   input  wire logic       run,
   input  wire logic       slow,
   input  wire logic       lf_tick,
   input  wire logic [1:0] sel,
   output logic            tick
);
   import eii_pkg::*;

   eii_div_type s_r, s_nxt;

   // interval code to counter mask
   function automatic logic [3:0] div_mask(input logic [1:0] code);
      case (code)
         2'h0:    div_mask = 4'h0;
         2'h1:    div_mask = 4'h3;
         2'h2:    div_mask = 4'h7;
         default: div_mask = 4'hF;
      endcase
   endfunction : div_mask

   // free counters, cleared while gated
   always_comb begin
      s_nxt = s_r;
      if (!run) begin
         s_nxt = '0;
      end else begin
         s_nxt.cnt = 4'(s_r.cnt + 4'h1);
         if (lf_tick) begin
            s_nxt.lfc = 2'(s_r.lfc + 2'h1);
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign tick = run && (slow ? (lf_tick && s_r.lfc == EII_LF_LAST)
                              : ((s_r.cnt & div_mask(sel)) == div_mask(sel)));

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   property p_slow_tick;
      slow && tick |-> lf_tick && s_r.lfc == EII_LF_LAST;
   endproperty
   a_slow_tick: assert property (p_slow_tick) else $error("slow tick off fs/4");

   property p_div16;
      run && !slow && sel == 2'h3 && tick |=> (!tick)[*8];
   endproperty
   a_div16: assert property (p_div16) else $error("div16 tick too early");
endmodule : eii_div
`default_nettype wire

// file: hdl/eii_nc.sv
/*
 * noise canceller for one pin: accepts a new level once two or three
 * consecutive samples agree. assumes pin is synchronous to core_clk.
 */
`default_nettype none
module eii_nc (
   input  wire logic core_clk,
   input  wire logic rst_n,
   input  wire logic run,
   input  wire logic tick,
   input  wire logic three,
   input  wire logic pin,
   output logic      level
);
   import eii_pkg::*;

   eii_nc_type s_r, s_nxt;

   always_comb begin
      s_nxt = s_r;
      if (!run) begin
         s_nxt = '0;
      end else if (tick) begin
         s_nxt.hist = {s_r.hist[0], pin};
         if (pin == s_r.hist[0] && (!three || pin == s_r.hist[1])) begin
            s_nxt.lvl = pin;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign level = s_r.lvl;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   property p_hold;
      run && !tick |=> $stable(level);
   endproperty
   a_hold: assert property (p_hold) else $error("level moved off tick");

   property p_vote3;
      run && tick && three && pin != s_r.hist[1] |=> $stable(level);
   endproperty
   a_vote3: assert property (p_vote3) else $error("accepted without 3 votes");
endmodule : eii_nc
`default_nettype wire

// file: hdl/eii_top.sv
/*
 * external interrupt inputs: six filtered pins, trigger detection,
 * request pulses, channel 4 control register and the clock gate bit.
 * assumes a register port answering one cycle after a read strobe,
 * an interrupt latch downstream, and channel 1-3 settings as inputs.
 */
`default_nettype none
module eii_top (
   input  wire logic                 core_clk,
   input  wire logic                 rst_n,
   input  wire eii_pkg::eii_bus_type bus,
   output logic [7:0]                rdata,
   input  wire logic [5:0]           ext_irq_pins,
   input  wire logic                 slow_mode,
   input  wire logic                 lf_tick,
   input  wire eii_pkg::eii_cfg_type [3:1] chan_cfg,
   output logic [5:0]                irq_req
);
   import eii_pkg::*;

   eii_top_type s_r, s_nxt;
   logic [5:0]  filt;
   logic [5:0]  tick;
   logic [5:0]  hit;
   logic [1:0]  sel_v [6];
   logic [1:0]  es_v  [6];
   logic [5:0]  three_v;

   // trigger decode shared by all channels
   function automatic logic trig(input logic [1:0] es,
                                 input logic       now,
                                 input logic       was,
                                 input logic       high_ok);
      case (es)
         EII_ES_RISE: trig = now && !was;
         EII_ES_FALL: trig = !now && was;
         EII_ES_BOTH: trig = now != was;
         EII_ES_HIGH: trig = high_ok && now;
         default:     trig = 1'b0;
      endcase
   endfunction : trig

   // per-channel settings, 0 and 5 fixed
   always_comb begin
      for (int i = 0; i < EII_NCH; i++) begin
         sel_v[i]   = 2'h0;
         es_v[i]    = EII_ES_FALL;
         three_v[i] = 1'b0;
      end
      for (int i = 1; i < 4; i++) begin
         sel_v[i]   = chan_cfg[i].sample_interval_select;
         es_v[i]    = chan_cfg[i].trigger_select;
         three_v[i] = !slow_mode;
      end
      sel_v[4]   = s_r.sample_interval_select;
      es_v[4]    = s_r.trigger_select;
      three_v[4] = !slow_mode;
   end

   // one divider and filter per channel
   for (genvar g = 0; g < EII_NCH; g++) begin : g_ch
      eii_div u_div (
         .core_clk (core_clk),
         .rst_n    (rst_n),
         .run      (s_r.ext_irq_clock_gate),
         .slow     (slow_mode),
         .lf_tick  (lf_tick),
         .sel      (sel_v[g]),
         .tick     (tick[g])
      );
      eii_nc u_nc (
         .core_clk (core_clk),
         .rst_n    (rst_n),
         .run      (s_r.ext_irq_clock_gate),
         .tick     (tick[g]),
         .three    (three_v[g]),
         .pin      (ext_irq_pins[g]),
         .level    (filt[g])
      );
      assign hit[g] = trig(es_v[g], filt[g], s_r.prev[g], g == 4);
   end

   // register port, edge tracking and request pulses
   always_comb begin
      s_nxt       = s_r;
      s_nxt.req   = '0;
      s_nxt.rdata = '0;
      if (bus.wr && bus.addr == EII_CTRL4_ADDR) begin
         s_nxt.trigger_select = bus.wdata[EII_ES_LSB +: 2];
         s_nxt.sample_interval_select = bus.wdata[EII_NC_LSB +: 2];
      end
      if (bus.wr && bus.addr == EII_POFF3_ADDR) begin
         s_nxt.ext_irq_clock_gate = bus.wdata[EII_GATE_BIT];
      end
      if (bus.rd && bus.addr == EII_CTRL4_ADDR) begin
         s_nxt.rdata[EII_LVL_BIT]         = s_r.captured_pass_level;
         s_nxt.rdata[EII_ES_LSB +: 2]     = s_r.trigger_select;
         s_nxt.rdata[EII_NC_LSB +: 2]     = s_r.sample_interval_select;
      end
      if (bus.rd && bus.addr == EII_POFF3_ADDR) begin
         s_nxt.rdata[EII_GATE_BIT] = s_r.ext_irq_clock_gate;
      end
      if (!s_r.ext_irq_clock_gate) begin
         s_nxt.prev = '0;
      end else begin
         s_nxt.prev = filt;
         s_nxt.req = hit;
         if (hit[4]) begin
            s_nxt.captured_pass_level = filt[4];
         end
      end
   end

   // gate and control clear on reset
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_r                        <= '0;
         s_r.ext_irq_clock_gate     <= EII_GATE_RST;
         s_r.trigger_select         <= EII_CTRL4_RST[EII_ES_LSB +: 2];
         s_r.sample_interval_select <= EII_CTRL4_RST[EII_NC_LSB +: 2];
      end else begin
         s_r <= s_nxt;
      end
   end

   assign rdata   = s_r.rdata;
   assign irq_req = s_r.req;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   property p_capture;
      s_r.req[4] |-> s_r.captured_pass_level == s_r.prev[4];
   endproperty
   a_capture: assert property (p_capture) else $error("level not captured");

   property p_both;
      s_r.ext_irq_clock_gate && s_r.trigger_select == EII_ES_BOTH
         && filt[4] != s_r.prev[4]
         |=> s_r.req[4] && s_r.captured_pass_level == $past(filt[4]);
   endproperty
   a_both: assert property (p_both) else $error("both-edge request lost");

   property p_fall;
      s_r.ext_irq_clock_gate && s_r.trigger_select == EII_ES_FALL
         && !filt[4] && s_r.prev[4] |=> s_r.req[4];
   endproperty
   a_fall: assert property (p_fall) else $error("falling edge missed");

   property p_rise;
      s_r.ext_irq_clock_gate && s_r.trigger_select == EII_ES_RISE
         && filt[4] && !s_r.prev[4] |=> s_r.req[4];
   endproperty
   a_rise: assert property (p_rise) else $error("rising edge missed");

   property p_level;
      s_r.ext_irq_clock_gate && s_r.trigger_select == EII_ES_HIGH
         && filt[4] [*2] |=> s_r.req[4];
   endproperty
   a_level: assert property (p_level) else $error("level request not repeated");

   property p_fixed;
      s_r.req[0] || s_r.req[5] |-> (s_r.req[0] ? !s_r.prev[0] && $past(s_r.prev[0])
                                              : !s_r.prev[5] && $past(s_r.prev[5]));
   endproperty
   a_fixed: assert property (p_fixed) else $error("fixed channel not falling");

   property p_rsvd;
      $past(bus.rd) |-> rdata[7:5] == 3'h0;
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved bits not zero");

   property p_gate;
      !s_r.ext_irq_clock_gate |=> irq_req == 6'h00 && filt == 6'h00;
   endproperty
   a_gate: assert property (p_gate) else $error("request while gated");
endmodule : eii_top
`default_nettype wire

// file: bench/eii_src.sv
/*
 * pin source model: drives the six external interrupt pins and the
 * low-frequency tick. assumes the bench asks for pin levels on want.
 */
`default_nettype none
module eii_src #(
   parameter int LF_DIV = 4
) (
   input  wire logic       core_clk,
   input  wire logic       rst_n,
   input  wire logic [5:0] want,
   output logic [5:0]      ext_irq_pins,
   output logic            lf_tick
);
   timeunit 1ns;
   timeprecision 1ns;
   int div_q;
   // idle-high pins until the first clock
   initial begin
      ext_irq_pins = 6'h3F;
      lf_tick = 1'b0;
      div_q = 0;
   end
   // pins move on the clock, like a synchronised port input
   always @(posedge core_clk) begin
      ext_irq_pins <= want;
      lf_tick      <= (div_q == LF_DIV - 1);
      div_q        <= (div_q == LF_DIV - 1) ? 0 : div_q + 1;
   end
endmodule : eii_src
`default_nettype wire

// file: bench/testbench.sv
/*
 * self-checking bench for the external interrupt inputs.
 * assumes the register port answers one cycle after a read strobe.
 */
`default_nettype none
module testbench;
   import eii_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic                   core_clk;
   logic                   rst_n;
   eii_bus_type            bus;
   logic [7:0]             rdata;
   logic [5:0]             ext_irq_pins;
   logic [5:0]             want;
   logic                   slow_mode;
   logic                   lf_tick;
   eii_cfg_type [3:1]      chan_cfg;
   logic [5:0]             irq_req;
   int                     cnt [6];
   int                     n_fail;
   int                     total_checks;
   int                     b4;

   eii_top eii_top_inst (.core_clk(core_clk), .rst_n(rst_n), .bus(bus), .rdata(rdata),
      .ext_irq_pins(ext_irq_pins), .slow_mode(slow_mode), .lf_tick(lf_tick),
      .chan_cfg(chan_cfg), .irq_req(irq_req));
   eii_src eii_src_inst (.core_clk(core_clk), .rst_n(rst_n), .want(want),
      .ext_irq_pins(ext_irq_pins), .lf_tick(lf_tick));

   // 20 MHz clock
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   // request pulse counters per channel
   always @(posedge core_clk) begin
      for (int i = 0; i < 6; i++) if (irq_req[i] === 1'b1) cnt[i]++;
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   task automatic stop_test;
      $display("checks=%0d mismatches=%0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : stop_test

   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge core_clk) begin
         bus.wr <= 1'b1;
         bus.addr <= a;
         bus.wdata <= d;
      end
      @(posedge core_clk) bus.wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [11:0] a, input logic [7:0] exp);
      @(posedge core_clk) begin
         bus.rd <= 1'b1;
         bus.addr <= a;
      end
      @(posedge core_clk) bus.rd <= 1'b0;
      #1 chk(rdata, exp);
   endtask : rd

   // low pulse of w cycles on channels m, then e requests expected on each
   task automatic pulse(input logic [5:0] m, input int w, input int s, input int e);
      int b [6];
      repeat (3) @(posedge core_clk);
      #1 b = cnt;
      @(posedge core_clk) want <= ~m;
      repeat (w) @(posedge core_clk);
      want <= 6'h3F;
      repeat (s) @(posedge core_clk);
      #1;
      for (int i = 0; i < 6; i++) chk(8'(cnt[i] - b[i]), m[i] ? 8'(e) : 8'h00);
   endtask : pulse

   // hang guard
   initial begin
      #1_000_000;
      n_fail++;
      stop_test;
   end

   initial begin
      rst_n = 1'b0;
      bus = '0;
      want = 6'h3F;
      slow_mode = 1'b0;
      chan_cfg = {4'h7, 4'h6, 4'h5}; // falling edge, intervals /4 /8 /16
      n_fail = 0;
      total_checks = 0;
      for (int i = 0; i < 6; i++) cnt[i] = 0;
      repeat (6) @(posedge core_clk);
      rst_n <= 1'b1;
      rd(EII_CTRL4_ADDR, 8'h00);
      rd(EII_POFF3_ADDR, 8'h00);
      rd(12'h000, 8'h00);
      pulse(6'h3F, 10, 40, 0);
      // software turns the clock on first
      wr(EII_POFF3_ADDR, 8'h01);
      rd(EII_POFF3_ADDR, 8'h01);
      repeat (40) @(posedge core_clk);
      pulse(6'h21, 3, 10, 1);
      for (int k = 1; k < 4; k++) begin
         pulse(6'(1 << k), (2 << (k + 1)) - 1, (4 << (k + 1)) + 8, 0);
         pulse(6'(1 << k), 4 << (k + 1), (4 << (k + 1)) + 8, 1);
      end
      // channel 4 edge codes and captured level
      for (int c = 0; c < 3; c++) begin
         wr(EII_CTRL4_ADDR, {4'h0, 2'(c), 2'b00});
         pulse(6'h10, 10, 20, (c == 2) ? 2 : 1);
         rd(EII_CTRL4_ADDR, {3'b000, 1'(c != 1), 2'(c), 2'b00});
      end
      wr(EII_CTRL4_ADDR, 8'hEC);
      repeat (3) @(posedge core_clk);
      #1 b4 = cnt[4];
      repeat (20) @(posedge core_clk);
      #1 chk(8'(cnt[4] - b4), 8'd20);
      rd(EII_CTRL4_ADDR, 8'h1C);
      wr(EII_CTRL4_ADDR, 8'h00);
      // slow mode, settle 15 low-frequency periods first
      slow_mode <= 1'b1;
      repeat (60) @(posedge core_clk);
      pulse(6'h03, 8, 100, 0);
      pulse(6'h03, 64, 100, 1);
      slow_mode <= 1'b0;
      repeat (60) @(posedge core_clk);
      pulse(6'h20, 3, 10, 1);
      stop_test;
   end
endmodule : testbench
`default_nettype wire
